// file: verilog/monitor_limit_regs.sv
`timescale 1ns/1ps
`include "monitor_limit_params.svh"

// Summary of operation
// - bus threshold bit 15 is reserved, ignores writes, always reads zero.
// - 15-bit bus over threshold, 3.125 mV step, checked against bus results.
// - 15-bit bus under threshold, 3.125 mV step, checked against bus results.
// - signed 16-bit temperature threshold compared directly with die temperature.
// - unsigned 16-bit power threshold, each step worth 256 power result steps.
// - resets: bus over and temperature 7fff, power ffff, bus under 0.
// - thresholds sit at pointers 0e, 0f, 10 and 11.
// - read-only 16-bit maker identity, ascii initials, fixed content.
// - read-only die identity: 12-bit die code above 4-bit revision.
// - range bit picks shunt step: clear 312.5 nV, set 78.125 nV.
// - shunt and bus results are 20 bits; shunt result is signed.
// - bus result is unsigned, 195.3125 uV per step.
// - die temperature is signed 16 bits, 7.8125 m-degree step.
// - temperature encoding spans about minus to plus 256 degrees.
// - bus result above the over threshold sets the bus over flag.
// - with latching on, flags hold until the alert register is read.

module monitor_limit_regs
    import monitor_limit_pkg::*;
#(
    parameter logic [6:0] TARGET_ADDR = `TARGET_ADDR
) (
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    // serial register port, open drain data
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_O,
    // converter results
    input wire results_s RESULT_I,
    // configuration and alert control
    input wire logic SHUNT_RANGE_SELECT_I,
    input wire logic ALERT_LATCH_ENABLE_I,
    input wire logic ALERT_READ_I,
    // outputs
    output logic signed [21:0] SHUNT_FINE_O,
    output limit_flags_s FLAGS_O
);
    // pin synchronisers
    logic scl_s1, scl_s2, scl_d;
    logic sda_s1, sda_s2, sda_d;

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_d <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_s1 <= SCL_I;
            scl_s2 <= scl_s1;
            scl_d <= scl_s2;
            sda_s1 <= SDA_I;
            sda_s2 <= sda_s1;
            sda_d <= sda_s2;
        end
    end

    logic scl_rise, scl_fall, start_det, stop_det;
    assign scl_rise = scl_s2 && !scl_d;
    assign scl_fall = !scl_s2 && scl_d;
    assign start_det = scl_s2 && scl_d && sda_d && !sda_s2;
    assign stop_det = scl_s2 && scl_d && !sda_d && sda_s2;

    // register file
    thresholds_s thr;
    thresholds_s next_thr;
    logic wr_en;
    logic [7:0] wr_ptr;
    logic [15:0] wr_data;

    always_comb begin
        next_thr = thr;
        if (wr_en) begin
            unique case (wr_ptr)
                `REG_BUS_OVER: next_thr.bus_over = wr_data[`BUS_THR_MSB:0];
                `REG_BUS_UNDER: next_thr.bus_under = wr_data[`BUS_THR_MSB:0];
                `REG_TEMP_OVER: next_thr.temp_over = wr_data;
                `REG_POWER_OVER: next_thr.power_over = wr_data;
                default: next_thr = thr;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            thr.bus_over <= `RST_BUS_OVER;
            thr.bus_under <= `RST_BUS_UNDER;
            thr.temp_over <= `RST_TEMP_OVER;
            thr.power_over <= `RST_POWER_OVER;
        end else begin
            thr <= next_thr;
        end
    end

    // unmapped pointers read as zero
    function automatic logic [15:0] read_reg(input logic [7:0] ptr, input thresholds_s t);
        logic [15:0] v;
        v = 16'h0000;
        unique case (ptr)
            `REG_BUS_OVER: v = {1'b0, t.bus_over};
            `REG_BUS_UNDER: v = {1'b0, t.bus_under};
            `REG_TEMP_OVER: v = t.temp_over;
            `REG_POWER_OVER: v = t.power_over;
            `REG_MAKER_ID: v = `MAKER_CODE;
            `REG_DIE_ID: v = {`DIE_CODE, `REVISION_CODE};
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

    // serial link state
    link_state_e state, next_state;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [7:0] shreg, next_shreg;
    logic [7:0] ptr, next_ptr;
    logic [7:0] msb, next_msb;
    logic [7:0] tx, next_tx;
    logic [15:0] rd_word, next_rd_word;
    logic byte_idx, next_byte_idx;
    logic rw, next_rw;
    logic nack, next_nack;
    logic sda_oe, next_sda_oe;
    logic next_wr_en;
    logic [15:0] next_wr_data;
    logic byte_done;

    assign byte_done = bit_cnt == 4'h8;

    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        next_ptr = ptr;
        next_msb = msb;
        next_tx = tx;
        next_rd_word = rd_word;
        next_byte_idx = byte_idx;
        next_rw = rw;
        next_nack = nack;
        next_sda_oe = sda_oe;
        next_wr_en = 1'b0;
        next_wr_data = wr_data;
        if (start_det) begin
            next_state = ST_ADDR;
            next_bit_cnt = 4'h0;
            next_sda_oe = 1'b0;
        end else if (stop_det) begin
            next_state = ST_IDLE;
            next_sda_oe = 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    next_sda_oe = 1'b0;
                end
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    if (scl_rise && !byte_done) begin
                        next_shreg = {shreg[6:0], sda_s2};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall && byte_done) begin
                        next_bit_cnt = 4'h0;
                        next_sda_oe = 1'b1;
                        if (state == ST_ADDR) begin
                            if (shreg[7:1] == TARGET_ADDR) begin
                                next_state = ST_ACK_ADDR;
                                next_rw = shreg[0];
                                next_byte_idx = 1'b0;
                                next_rd_word = read_reg(ptr, thr);
                            end else begin
                                // other target: stay quiet until the next start
                                next_state = ST_IDLE;
                                next_sda_oe = 1'b0;
                            end
                        end else if (state == ST_PTR) begin
                            next_ptr = shreg;
                            next_state = ST_ACK_PTR;
                        end else begin
                            next_state = ST_ACK_W;
                            if (!byte_idx) begin
                                next_msb = shreg;
                            end else begin
                                next_wr_data = {msb, shreg};
                                next_wr_en = 1'b1;
                            end
                        end
                    end
                end
                ST_ACK_ADDR: begin
                    if (scl_fall) begin
                        if (rw) begin
                            next_state = ST_RDATA;
                            next_tx = rd_word[15:8];
                            next_sda_oe = !rd_word[15];
                        end else begin
                            next_state = ST_PTR;
                            next_sda_oe = 1'b0;
                        end
                    end
                end
                ST_ACK_PTR: begin
                    if (scl_fall) begin
                        next_state = ST_WDATA;
                        next_byte_idx = 1'b0;
                        next_sda_oe = 1'b0;
                    end
                end
                ST_ACK_W: begin
                    if (scl_fall) begin
                        next_state = ST_WDATA;
                        next_byte_idx = !byte_idx;
                        next_sda_oe = 1'b0;
                    end
                end
                ST_RDATA: begin
                    if (scl_rise) begin
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (byte_done) begin
                            next_state = ST_ACK_R;
                            next_sda_oe = 1'b0;
                        end else begin
                            next_tx = {tx[6:0], 1'b0};
                            next_sda_oe = !tx[6];
                        end
                    end
                end
                ST_ACK_R: begin
                    if (scl_rise) begin
                        next_nack = sda_s2;
                    end else if (scl_fall) begin
                        next_bit_cnt = 4'h0;
                        if (nack) begin
                            next_state = ST_IDLE;
                        end else begin
                            // words repeat high byte first; pointer never advances
                            next_state = ST_RDATA;
                            next_byte_idx = !byte_idx;
                            next_tx = byte_idx ? rd_word[15:8] : rd_word[7:0];
                            next_sda_oe = byte_idx ? !rd_word[15] : !rd_word[7];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            ptr <= 8'h00;
            msb <= 8'h00;
            tx <= 8'h00;
            rd_word <= 16'h0000;
            byte_idx <= 1'b0;
            rw <= 1'b0;
            nack <= 1'b0;
            sda_oe <= 1'b0;
            wr_en <= 1'b0;
            wr_data <= 16'h0000;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            ptr <= next_ptr;
            msb <= next_msb;
            tx <= next_tx;
            rd_word <= next_rd_word;
            byte_idx <= next_byte_idx;
            rw <= next_rw;
            nack <= next_nack;
            sda_oe <= next_sda_oe;
            wr_en <= next_wr_en;
            wr_data <= next_wr_data;
        end
    end

    assign wr_ptr = ptr;
    assign SDA_O = 1'b0;
    assign SDA_OE_O = sda_oe;

    // shunt result scaled to the fine step, sign kept for reverse current
    logic signed [21:0] shunt_fine, next_shunt_fine;

    always_comb begin
        if (SHUNT_RANGE_SELECT_I) begin
            next_shunt_fine = {{2{RESULT_I.shunt[19]}}, RESULT_I.shunt};
        end else begin
            next_shunt_fine = {RESULT_I.shunt, {`SHUNT_COARSE_SHIFT{1'b0}}};
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            shunt_fine <= 22'sh0;
        end else begin
            shunt_fine <= next_shunt_fine;
        end
    end

    assign SHUNT_FINE_O = shunt_fine;

    // bus result is unsigned and temperature signed, both at native scale
    limit_compare u_limit_compare (
        .clk_i(SYS_CLK_I),
        .rst_i(RST_I),
        .results_i(RESULT_I),
        .thr_i(thr),
        .latch_en_i(ALERT_LATCH_ENABLE_I),
        .alert_read_i(ALERT_READ_I),
        .flags_o(FLAGS_O)
    );
endmodule

// file: verilog/monitor_limit_params.svh
`ifndef MONITOR_LIMIT_PARAMS_SVH
`define MONITOR_LIMIT_PARAMS_SVH

// register pointer values
`define REG_BUS_OVER 8'h0e
`define REG_BUS_UNDER 8'h0f
`define REG_TEMP_OVER 8'h10
`define REG_POWER_OVER 8'h11
`define REG_MAKER_ID 8'h3e
`define REG_DIE_ID 8'h3f

// reset values
`define RST_BUS_OVER 15'h7fff
`define RST_BUS_UNDER 15'h0000
`define RST_TEMP_OVER 16'h7fff
`define RST_POWER_OVER 16'hffff

// field layout
`define BUS_THR_MSB 14
`define DIE_CODE_LSB 4
`define REV_CODE_MSB 3

// identity values, arbitrary
`define MAKER_CODE 16'h5858
`define DIE_CODE 12'h3a5
`define REVISION_CODE 4'h7

// threshold scaling: 3.125 mV over 195.3125 uV is 16, power threshold lsb is 256 result lsbs
`define BUS_THR_SHIFT 4
`define POWER_THR_SHIFT 8
// shunt fine step 78.125 nV; coarse 312.5 nV is four fine steps
`define SHUNT_COARSE_SHIFT 2

// serial target address, arbitrary default
`define TARGET_ADDR 7'h40

`endif

// file: verilog/monitor_limit_pkg.sv
package monitor_limit_pkg;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ACK_ADDR = 4'h2,
        ST_PTR = 4'h3,
        ST_ACK_PTR = 4'h4,
        ST_WDATA = 4'h5,
        ST_ACK_W = 4'h6,
        ST_RDATA = 4'h7,
        ST_ACK_R = 4'h8
    } link_state_e;

    // converter results with one-cycle completion strobes
    typedef struct packed {
        logic signed [19:0] shunt;
        logic [19:0] bus;
        logic signed [15:0] temp;
        logic [23:0] power;
        logic bus_done;
        logic temp_done;
        logic power_done;
    } results_s;

    typedef struct packed {
        logic [14:0] bus_over;
        logic [14:0] bus_under;
        logic signed [15:0] temp_over;
        logic [15:0] power_over;
    } thresholds_s;

    typedef struct packed {
        logic bus_over;
        logic bus_under;
        logic temp_over;
        logic power_over;
    } limit_flags_s;

endpackage

// file: verilog/limit_compare.sv
`timescale 1ns/1ps
`include "monitor_limit_params.svh"

module limit_compare
    import monitor_limit_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // results and limits
    input wire results_s results_i,
    input wire thresholds_s thr_i,
    // alert control
    input wire logic latch_en_i,
    input wire logic alert_read_i,
    // flags
    output limit_flags_s flags_o
);
    limit_flags_s flags;
    limit_flags_s next_flags;
    logic [19:0] bus_over_lim;
    logic [19:0] bus_under_lim;
    logic [23:0] power_lim;
    logic trip_bo, trip_bu, trip_t, trip_p;

    // threshold lsb is a multiple of the result lsb, so shift the threshold up rather than truncate the result
    assign bus_over_lim = {1'b0, thr_i.bus_over, {`BUS_THR_SHIFT{1'b0}}};
    assign bus_under_lim = {1'b0, thr_i.bus_under, {`BUS_THR_SHIFT{1'b0}}};
    assign power_lim = {thr_i.power_over, {`POWER_THR_SHIFT{1'b0}}};

    assign trip_bo = results_i.bus > bus_over_lim;
    assign trip_bu = results_i.bus < bus_under_lim;
    // explicit signed compare: a struct member select must not fall back to unsigned
    assign trip_t = $signed(results_i.temp) > $signed(thr_i.temp_over);
    assign trip_p = results_i.power > power_lim;

    function automatic logic next_flag(input logic cur, input logic done, input logic trip,
                                       input logic latch, input logic rd);
        logic v;
        v = cur;
        if (latch) begin
            if (rd) begin
                v = 1'b0;
            end
            if (done && trip) begin
                v = 1'b1;
            end
        end else if (done) begin
            v = trip;
        end
        return v;
    endfunction

    // set wins over a read in the same cycle
    always_comb begin
        next_flags.bus_over = next_flag(flags.bus_over, results_i.bus_done, trip_bo, latch_en_i,
                                        alert_read_i);
        next_flags.bus_under = next_flag(flags.bus_under, results_i.bus_done, trip_bu, latch_en_i,
                                         alert_read_i);
        next_flags.temp_over = next_flag(flags.temp_over, results_i.temp_done, trip_t, latch_en_i,
                                         alert_read_i);
        next_flags.power_over = next_flag(flags.power_over, results_i.power_done, trip_p, latch_en_i,
                                          alert_read_i);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end

    assign flags_o = flags;
endmodule

// file: verif/monitor_limit_checker.sv
`timescale 1ns/1ps
module monitor_limit_checker
    import monitor_limit_pkg::*;
(
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    // watched ports
    input wire logic SDA_OE_O,
    input wire results_s RESULT_I,
    input wire logic SHUNT_RANGE_SELECT_I,
    input wire logic ALERT_LATCH_ENABLE_I,
    input wire logic ALERT_READ_I,
    input wire logic signed [21:0] SHUNT_FINE_O,
    input wire limit_flags_s FLAGS_O
);
    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (RST_I);
    wire logic any_done = RESULT_I.bus_done || RESULT_I.temp_done || RESULT_I.power_done;
    a_reset_quiet: assert property ($fell(RST_I) |-> !SDA_OE_O && FLAGS_O == '0 && SHUNT_FINE_O == '0)
        else $error("outputs not quiet after reset");
    // extreme results trip or clear whatever the threshold holds
    a_bus_over_max: assert property (RESULT_I.bus_done && RESULT_I.bus == 20'hfffff |=> FLAGS_O.bus_over)
        else $error("bus over flag missing at full scale");
    a_bus_over_zero: assert property (RESULT_I.bus_done && RESULT_I.bus == 20'h0 && !ALERT_LATCH_ENABLE_I
        |=> !FLAGS_O.bus_over)
        else $error("bus over flag set at zero");
    a_temp_signed: assert property (RESULT_I.temp_done && RESULT_I.temp == 16'h8000 && !ALERT_LATCH_ENABLE_I
        |=> !FLAGS_O.temp_over)
        else $error("temp over flag set at most negative");
    a_power_max: assert property (RESULT_I.power_done && RESULT_I.power == 24'hffffff |=> FLAGS_O.power_over)
        else $error("power over flag missing at full scale");
    a_flags_steady: assert property (!any_done && !ALERT_READ_I |=> $stable(FLAGS_O))
        else $error("flags moved without a conversion");
    a_latch_clear: assert property (ALERT_LATCH_ENABLE_I && ALERT_READ_I && !any_done |=> FLAGS_O == '0)
        else $error("latched flags not cleared by read");
    a_latch_hold: assert property (ALERT_LATCH_ENABLE_I && FLAGS_O.bus_over && !ALERT_READ_I
        |=> FLAGS_O.bus_over)
        else $error("latched flag dropped");
    a_shunt_fine: assert property (SHUNT_RANGE_SELECT_I
        |=> SHUNT_FINE_O == {{2{$past(RESULT_I.shunt[19])}}, $past(RESULT_I.shunt)})
        else $error("fine shunt scaling wrong");
    a_shunt_coarse: assert property (!SHUNT_RANGE_SELECT_I
        |=> SHUNT_FINE_O == {$past(RESULT_I.shunt), 2'b00})
        else $error("coarse shunt scaling wrong");
    c_bus_over: cover property (FLAGS_O.bus_over);
    c_latched_read: cover property (ALERT_LATCH_ENABLE_I && ALERT_READ_I && FLAGS_O != '0);
    c_ack: cover property ($rose(SDA_OE_O));
endmodule

bind monitor_limit_regs monitor_limit_checker chk (
    .SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .SDA_OE_O(SDA_OE_O), .RESULT_I(RESULT_I),
    .SHUNT_RANGE_SELECT_I(SHUNT_RANGE_SELECT_I), .ALERT_LATCH_ENABLE_I(ALERT_LATCH_ENABLE_I),
    .ALERT_READ_I(ALERT_READ_I), .SHUNT_FINE_O(SHUNT_FINE_O), .FLAGS_O(FLAGS_O));

// file: verif/serial_host_model.sv
`timescale 1ns/1ps
module serial_host_model (
    // clock
    input wire logic clk_i,
    // wired data line and host pins
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    int half = 10;
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // pins move just after an edge, never on it
    task automatic step(input logic c, input logic low, input int n);
        @(posedge clk_i);
        scl_o <= c;
        sda_low_o <= low;
        repeat (n) @(posedge clk_i);
    endtask
    // data held 4 clocks past the fall so no false start or stop
    task automatic start();
        step(1'b0, sda_low_o, 4);
        step(1'b0, 1'b0, 4);
        step(1'b1, 1'b0, half);
        step(1'b1, 1'b1, half);
    endtask
    task automatic stop();
        step(1'b0, sda_low_o, 4);
        step(1'b0, 1'b1, 4);
        step(1'b1, 1'b1, half);
        step(1'b1, 1'b0, half);
    endtask
    task automatic byte9(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            step(1'b0, sda_low_o, 4);
            step(1'b0, !tx[i], half);
            step(1'b1, !tx[i], half);
            rx[i] = sda_i;
        end
    endtask
endmodule

// file: verif/tb_top.sv
`timescale 1ns/1ps
`include "monitor_limit_params.svh"
module tb_top
    import monitor_limit_pkg::*;
;
    localparam logic [6:0] ADDR = 7'h40;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic range_sel = 1'b1;
    logic latch_en = 1'b0;
    logic alert_rd = 1'b0;
    results_s res = '0;
    logic scl;
    logic sda_low;
    logic sda_o;
    logic sda_oe;
    logic signed [21:0] shunt_fine;
    limit_flags_s flags;
    int n_errors = 0;
    int n_compared = 0;
    // pull-up on the open drain line
    wire logic sda = !(sda_low || sda_oe);

    always #25 clk = ~clk;

    monitor_limit_regs #(.TARGET_ADDR(ADDR)) DUT (
        .SYS_CLK_I(clk), .RST_I(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(sda_oe),
        .RESULT_I(res), .SHUNT_RANGE_SELECT_I(range_sel), .ALERT_LATCH_ENABLE_I(latch_en),
        .ALERT_READ_I(alert_rd), .SHUNT_FINE_O(shunt_fine), .FLAGS_O(flags));
    serial_host_model host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));

    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic sb(input logic [7:0] b, input logic nack);
        logic [8:0] r;
        host.byte9({b, 1'b1}, r);
        check("ack", {23'h0, r[0]}, {23'h0, nack});
    endtask
    task automatic wr(input logic [7:0] p, input logic [15:0] d);
        host.start();
        sb({ADDR, 1'b0}, 1'b0);
        sb(p, 1'b0);
        sb(d[15:8], 1'b0);
        sb(d[7:0], 1'b0);
        host.stop();
    endtask
    // pointer write then repeated start into the read
    task automatic rd(input string name, input logic [7:0] p, input logic [15:0] e);
        logic [8:0] hi;
        logic [8:0] lo;
        host.start();
        sb({ADDR, 1'b0}, 1'b0);
        sb(p, 1'b0);
        host.start();
        sb({ADDR, 1'b1}, 1'b0);
        host.byte9(9'h1fe, hi);
        host.byte9(9'h1ff, lo);
        host.stop();
        check(name, {8'h0, hi[8:1], lo[8:1]}, {8'h0, e});
    endtask
    task automatic cmp(input string name, input int k, input logic [23:0] v, input int i, input logic e);
        @(posedge clk);
        res.bus <= v[19:0];
        res.temp <= v[15:0];
        res.power <= v;
        res.bus_done <= (k == 0);
        res.temp_done <= (k == 1);
        res.power_done <= (k == 2);
        @(posedge clk);
        res.bus_done <= 1'b0;
        res.temp_done <= 1'b0;
        res.power_done <= 1'b0;
        @(posedge clk);
        #1;
        check(name, {23'h0, flags[i]}, {23'h0, e});
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        rd("bus_over_thr", 8'h0e, 16'h7fff);
        rd("bus_under_thr", 8'h0f, 16'h0000);
        rd("temp_thr", 8'h10, 16'h7fff);
        rd("power_thr", 8'h11, 16'hffff);
        rd("die_id", 8'h3f, {`DIE_CODE, `REVISION_CODE});
        wr(8'h3e, 16'h0000);
        rd("maker_id", 8'h3e, `MAKER_CODE);
        rd("unmapped", 8'h20, 16'h0000);
        wr(8'h0e, 16'h8100);
        wr(8'h0f, 16'h8080);
        wr(8'h10, 16'hff00);
        host.half = 30;
        wr(8'h11, 16'h0012);
        rd("power_thr", 8'h11, 16'h0012);
        host.half = 10;
        rd("bus_over_thr", 8'h0e, 16'h0100);
        rd("bus_under_thr", 8'h0f, 16'h0080);
        rd("temp_thr", 8'h10, 16'hff00);
        host.start();
        sb({ADDR ^ 7'h01, 1'b0}, 1'b1);
        host.stop();
        cmp("bus_over", 0, 24'h0, 3, 1'b0);
        cmp("bus_over", 0, 24'h01000, 3, 1'b0);
        cmp("bus_over", 0, 24'h01001, 3, 1'b1);
        cmp("bus_over", 0, 24'h80000, 3, 1'b1);
        cmp("bus_under", 0, 24'h007ff, 2, 1'b1);
        cmp("bus_under", 0, 24'h00800, 2, 1'b0);
        cmp("temp_over", 1, 24'h00ff00, 1, 1'b0);
        cmp("temp_over", 1, 24'h00ff01, 1, 1'b1);
        cmp("temp_over", 1, 24'h007fff, 1, 1'b1);
        cmp("temp_over", 1, 24'h008000, 1, 1'b0);
        cmp("power_over", 2, 24'h001201, 0, 1'b1);
        cmp("power_over", 2, 24'hffffff, 0, 1'b1);
        cmp("power_over", 2, 24'h001200, 0, 1'b0);
        @(posedge clk);
        latch_en <= 1'b1;
        cmp("bus_over", 0, 24'h0fffff, 3, 1'b1);
        cmp("bus_over", 0, 24'h0, 3, 1'b1);
        @(posedge clk);
        alert_rd <= 1'b1;
        @(posedge clk);
        alert_rd <= 1'b0;
        @(posedge clk);
        #1;
        check("flags", {20'h0, flags}, 24'h0);
        @(posedge clk);
        res.shunt <= 20'hffffd;
        repeat (2) @(posedge clk);
        #1;
        check("shunt_fine", {2'b0, shunt_fine}, 24'h3ffffd);
        @(posedge clk);
        range_sel <= 1'b0;
        res.shunt <= 20'h7ffff;
        repeat (2) @(posedge clk);
        #1;
        check("shunt_coarse", {2'b0, shunt_fine}, 24'h1ffffc);
        conclude();
    end

    initial begin
        repeat (90000) @(posedge clk);
        n_errors++;
        conclude();
    end
endmodule
